// File: comp_diag_pkg.sv
`default_nettype none
package comp_diag_pkg;
  // =========================================================
  // register map (printed offsets are indices, byte = 4*index)
  localparam logic [7:0] idx_cell_open_uv = 8'h3E;
  localparam logic [7:0] idx_ratio_aux_open_uv = 8'h3F;
  localparam logic [7:0] idx_abs_aux_open_uv = 8'h40;
  localparam logic [7:0] idx_comp_accuracy_ov = 8'h41;
  localparam logic [7:0] idx_ctrl = 8'h50;
  localparam logic [7:0] idx_status = 8'h51;
  localparam logic [7:0] idx_mask = 8'h52;
  localparam int addr_w = 10;
  // =========================================================
  // field layout
  localparam int lim_lsb = 6;
  localparam int lim_msb = 15;
  localparam int lim_w = 10;
  localparam logic [9:0] cell_open_uv_rst = 10'h000;
  localparam logic [9:0] aux_open_uv_rst = 10'h000;
  localparam logic [9:0] comp_accuracy_ov_rst = 10'h3FF;
  localparam logic [9:0] lim_zero = 10'h000;
  localparam logic [9:0] lim_ones = 10'h3FF;
  // ctrl register bits
  localparam int ctrl_scan_lsb = 0;
  localparam int ctrl_acc_en_bit = 4;
  localparam int ctrl_cell_open_bit = 5;
  localparam int ctrl_aux_diag_bit = 6;
  localparam logic [2:0] scan_cfg_a = 3'h1;
  localparam logic [2:0] scan_cfg_b = 3'h2;
  // status / mask bits
  localparam int st_cell_uv = 0;
  localparam int st_aux_uv = 1;
  localparam int st_acc_ov = 2;
  localparam int st_w = 3;
  // axi responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // sample kinds
  localparam logic [1:0] kind_cell = 2'h0;
  localparam logic [1:0] kind_aux = 2'h1;
  localparam logic [1:0] kind_acc = 2'h2;
endpackage
`default_nettype wire

// File: comp_diag_thresholds.sv
// Operation
// - cell open limit; low open result flags
// - zero cell limit never flags
// - ratiometric aux limit used when refsel 0
// - absolute aux limit used when refsel 1
// - zero aux limit disables its alert
// - accuracy check only scan 001/010, enabled
// - accuracy path set by analog sequencer
// - accuracy overvoltage limit, 10 bits
// - result above limit sets accuracy alert
// - accuracy limit resets all ones, disabled
`timescale 1ns/1ps
`default_nettype none
module comp_diag_thresholds (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [comp_diag_pkg::addr_w-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [comp_diag_pkg::addr_w-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic [1:0] sample_kind,
  input wire logic [comp_diag_pkg::lim_w-1:0] sample_result,
  input wire logic aux_reference_select,
  input wire logic seq_done,
  output logic acc_check_start,
  output logic cell_comp_uv_alert,
  output logic aux_comp_uv_alert,
  output logic comp_accuracy_ov_alert,
  output logic irq
);
  import comp_diag_pkg::*;

  // =========================================================
  // registers
  logic [9:0] cell_open_uv_field_ff;
  logic [9:0] ratio_aux_open_uv_field_ff;
  logic [9:0] abs_aux_open_uv_field_ff;
  logic [9:0] comp_accuracy_ov_field_ff;
  logic [6:0] ctrl_ff;
  logic [st_w-1:0] status_ff;
  logic [st_w-1:0] mask_ff;
  logic [st_w-1:0] nxt_status;
  logic [addr_w-1:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  // turns a byte address into a register index
  function automatic logic [7:0] word_idx(input logic [addr_w-1:0] a);
    word_idx = a[addr_w-1:2];
  endfunction

  // true for any mapped index
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == idx_cell_open_uv) || (i == idx_ratio_aux_open_uv) ||
      (i == idx_abs_aux_open_uv) || (i == idx_comp_accuracy_ov) ||
      (i == idx_ctrl) || (i == idx_status) || (i == idx_mask);
  endfunction

  // limit field placed in bits 15:6, low bits zero
  function automatic logic [31:0] lim_word(input logic [9:0] v);
    lim_word = {16'h0000, v, 6'h00};
  endfunction

  // =========================================================
  // axi write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign wr_fire = aw_held_ff && w_held_ff;
  assign wr_idx = word_idx(awaddr_ff);
  assign wr_ok = is_mapped(wr_idx);

  // capture address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // limit and control registers; bits 5:0 of limits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_open_uv_field_ff <= cell_open_uv_rst;
      ratio_aux_open_uv_field_ff <= aux_open_uv_rst;
      abs_aux_open_uv_field_ff <= aux_open_uv_rst;
      comp_accuracy_ov_field_ff <= comp_accuracy_ov_rst;
      ctrl_ff <= 7'h00;
      mask_ff <= '0;
    end else if (wr_fire) begin
      if (wr_idx == idx_cell_open_uv) begin
        if (wstrb_ff[0]) cell_open_uv_field_ff[1:0] <= wdata_ff[7:6];
        if (wstrb_ff[1]) cell_open_uv_field_ff[9:2] <= wdata_ff[15:8];
      end
      if (wr_idx == idx_ratio_aux_open_uv) begin
        if (wstrb_ff[0]) ratio_aux_open_uv_field_ff[1:0] <= wdata_ff[7:6];
        if (wstrb_ff[1]) ratio_aux_open_uv_field_ff[9:2] <= wdata_ff[15:8];
      end
      if (wr_idx == idx_abs_aux_open_uv) begin
        if (wstrb_ff[0]) abs_aux_open_uv_field_ff[1:0] <= wdata_ff[7:6];
        if (wstrb_ff[1]) abs_aux_open_uv_field_ff[9:2] <= wdata_ff[15:8];
      end
      if (wr_idx == idx_comp_accuracy_ov) begin
        if (wstrb_ff[0]) comp_accuracy_ov_field_ff[1:0] <= wdata_ff[7:6];
        if (wstrb_ff[1]) comp_accuracy_ov_field_ff[9:2] <= wdata_ff[15:8];
      end
      if (wr_idx == idx_ctrl && wstrb_ff[0]) begin
        ctrl_ff <= wdata_ff[6:0];
      end
      if (wr_idx == idx_mask && wstrb_ff[0]) begin
        mask_ff <= wdata_ff[st_w-1:0];
      end
    end
  end

  // =========================================================
  // axi read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = word_idx(s_axi_araddr);

  // read mux
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    if (rd_idx == idx_cell_open_uv) begin
      rd_word = lim_word(cell_open_uv_field_ff);
    end else if (rd_idx == idx_ratio_aux_open_uv) begin
      rd_word = lim_word(ratio_aux_open_uv_field_ff);
    end else if (rd_idx == idx_abs_aux_open_uv) begin
      rd_word = lim_word(abs_aux_open_uv_field_ff);
    end else if (rd_idx == idx_comp_accuracy_ov) begin
      rd_word = lim_word(comp_accuracy_ov_field_ff);
    end else if (rd_idx == idx_ctrl) begin
      rd_word = {25'h0000000, ctrl_ff};
    end else if (rd_idx == idx_status) begin
      rd_word = {29'h00000000, status_ff};
    end else if (rd_idx == idx_mask) begin
      rd_word = {29'h00000000, mask_ff};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? resp_okay : resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =========================================================
  // compare logic
  logic cell_open_diag_select;
  logic aux_diag_select;
  logic comp_accuracy_enable;
  logic [2:0] scan_config;
  logic acc_allowed;
  logic [9:0] aux_limit;
  logic hit_cell;
  logic hit_aux;
  logic hit_acc;
  logic ev_cell;
  logic ev_aux;
  logic ev_acc;

  assign scan_config = ctrl_ff[ctrl_scan_lsb+2:ctrl_scan_lsb];
  assign comp_accuracy_enable = ctrl_ff[ctrl_acc_en_bit];
  assign cell_open_diag_select = ctrl_ff[ctrl_cell_open_bit];
  assign aux_diag_select = ctrl_ff[ctrl_aux_diag_bit];
  // accuracy check runs only for these scan setups
  assign acc_allowed = comp_accuracy_enable &&
    (scan_config == scan_cfg_a || scan_config == scan_cfg_b);
  // path setup (vref through second shifter) is the sequencer's job
  assign acc_check_start = seq_done && acc_allowed;
  // limit chosen by reference select
  assign aux_limit = aux_reference_select ? abs_aux_open_uv_field_ff :
    ratio_aux_open_uv_field_ff;

  limit_compare u_cell_cmp (
    .result(sample_result),
    .limit(cell_open_uv_field_ff),
    .check_over(1'b0),
    .hit(hit_cell)
  );
  limit_compare u_aux_cmp (
    .result(sample_result),
    .limit(aux_limit),
    .check_over(1'b0),
    .hit(hit_aux)
  );
  limit_compare u_acc_cmp (
    .result(sample_result),
    .limit(comp_accuracy_ov_field_ff),
    .check_over(1'b1),
    .hit(hit_acc)
  );

  // events; zero limit cannot hit under strict less-than
  assign ev_cell = sample_valid && sample_kind == kind_cell &&
    cell_open_diag_select && hit_cell;
  assign ev_aux = sample_valid && sample_kind == kind_aux &&
    aux_diag_select && hit_aux;
  // all-ones limit can never be exceeded
  assign ev_acc = sample_valid && sample_kind == kind_acc &&
    hit_acc;

  // =========================================================
  // sticky status, write one clears, set wins
  always_comb begin
    nxt_status = status_ff;
    if (wr_fire && wr_idx == idx_status && wstrb_ff[0]) begin
      nxt_status = status_ff & ~wdata_ff[st_w-1:0];
    end
    nxt_status[st_cell_uv] = nxt_status[st_cell_uv] | ev_cell;
    nxt_status[st_aux_uv] = nxt_status[st_aux_uv] | ev_aux;
    nxt_status[st_acc_ov] = nxt_status[st_acc_ov] | ev_acc;
  end

  // status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign cell_comp_uv_alert = status_ff[st_cell_uv];
  assign aux_comp_uv_alert = status_ff[st_aux_uv];
  assign comp_accuracy_ov_alert = status_ff[st_acc_ov];
  assign irq = |(status_ff & mask_ff);

  // =========================================================
  // assertions
  // read taken of a limit word or an unmapped place
  sequence lim_rd_s;
    s_axi_arvalid && s_axi_arready && rd_idx != idx_ctrl &&
      rd_idx != idx_status && rd_idx != idx_mask;
  endsequence
  // full write of the accuracy limit about to land
  sequence acc_wr_s;
    wr_fire && wr_idx == idx_comp_accuracy_ov && wstrb_ff[1:0] == 2'h3;
  endsequence
  cell_alert_set_a: assert property (@(posedge aclk)
    disable iff (!aresetn) ev_cell |=> cell_comp_uv_alert)
    else $error("cell alert not set");
  cell_zero_a: assert property (@(posedge aclk)
    disable iff (!aresetn) (cell_open_uv_field_ff == lim_zero) |-> !ev_cell)
    else $error("zero cell limit flagged");
  ratio_aux_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (sample_valid && sample_kind == kind_aux && aux_diag_select &&
     !aux_reference_select &&
     sample_result < ratio_aux_open_uv_field_ff) |=> aux_comp_uv_alert)
    else $error("ratio aux alert missing");
  abs_aux_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (sample_valid && sample_kind == kind_aux && aux_diag_select &&
     aux_reference_select &&
     sample_result < abs_aux_open_uv_field_ff) |=> aux_comp_uv_alert)
    else $error("abs aux alert missing");
  aux_zero_a: assert property (@(posedge aclk)
    disable iff (!aresetn) (aux_limit == lim_zero) |-> !ev_aux)
    else $error("zero aux limit flagged");
  acc_gate_a: assert property (@(posedge aclk)
    disable iff (!aresetn) acc_check_start == (seq_done &&
    comp_accuracy_enable &&
    (scan_config == scan_cfg_a || scan_config == scan_cfg_b)))
    else $error("accuracy check badly gated");
  acc_set_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (sample_valid && sample_kind == kind_acc &&
     sample_result > comp_accuracy_ov_field_ff) |=> comp_accuracy_ov_alert)
    else $error("accuracy alert missing");
  acc_ones_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (comp_accuracy_ov_field_ff == lim_ones) |-> !ev_acc)
    else $error("all ones limit flagged");
  acc_write_a: assert property (@(posedge aclk)
    disable iff (!aresetn) acc_wr_s |=> lim_word(comp_accuracy_ov_field_ff)
    == ($past(wdata_ff) & 32'h0000_FFC0))
    else $error("accuracy limit write lost");
  low_bits_a: assert property (@(posedge aclk)
    disable iff (!aresetn) lim_rd_s |=> s_axi_rdata[5:0] == 6'h00)
    else $error("limit low bits not zero");
  sticky_hold_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (comp_accuracy_ov_alert && !wr_fire) |=> comp_accuracy_ov_alert)
    else $error("status bit lost");
  irq_mask_a: assert property (@(posedge aclk)
    disable iff (!aresetn) (mask_ff == '0) |-> !irq)
    else $error("masked alert raised irq");
  irq_raise_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (comp_accuracy_ov_alert && mask_ff[st_acc_ov]) |-> irq)
    else $error("unmasked alert left irq low");
endmodule // comp_diag_thresholds
`default_nettype wire

// File: comparator_diag_thresholds_tb.sv
`timescale 1ns/1ps
`default_nettype none
module comparator_diag_thresholds_tb;
  import comp_diag_pkg::*;
  // =========================================================
  // stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [addr_w-1:0] s_axi_awaddr = '0;
  logic [addr_w-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sample_valid = 1'b0;
  logic [1:0] sample_kind = '0;
  logic [lim_w-1:0] sample_result = '0;
  logic aux_reference_select = 1'b0;
  logic seq_done = 1'b0;
  logic acc_check_start, cell_comp_uv_alert, aux_comp_uv_alert;
  logic comp_accuracy_ov_alert, irq;
  logic [2:0] msk = 3'h0;
  int miscompares = 0;
  int checked = 0;

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  comp_diag_thresholds dut_u (
    .aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sample_valid, .sample_kind, .sample_result, .aux_reference_select,
    .seq_done, .acc_check_start, .cell_comp_uv_alert,
    .aux_comp_uv_alert, .comp_accuracy_ov_alert, .irq
  );

  // =========================================================
  // helpers
  task automatic complete_run;
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // axi write; ready seen at negedge is what the next rising edge samples
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] er = resp_okay,
                    input logic [3:0] st = 4'hF);
    logic aw_hs, w_hs, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_hs) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hs) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // axi read with expected data and response
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input logic [1:0] er = resp_okay);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // one comparator result, settled alert visible at the negedge after
  task automatic smp(input logic [1:0] k, input logic [9:0] r,
                     input logic rs);
    @(posedge aclk);
    sample_valid <= 1'b1;
    sample_kind <= k;
    sample_result <= r;
    aux_reference_select <= rs;
    @(posedge aclk);
    sample_valid <= 1'b0;
    @(negedge aclk);
  endtask

  // compare alerts and irq, then clear every status bit
  task automatic al(input logic [2:0] e);
    chk({comp_accuracy_ov_alert, aux_comp_uv_alert, cell_comp_uv_alert}, e);
    chk(irq, |(e & msk));
    wr(idx_status, 32'h7);
  endtask

  function automatic logic [31:0] lim(input logic [9:0] v);
    return {16'h0, v, 6'h00};
  endfunction

  // =========================================================
  // watchdog
  initial begin
    repeat (8000) @(posedge aclk);
    miscompares++;
    complete_run();
  end

  // =========================================================
  // test sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(idx_cell_open_uv, lim(10'h000));
    rd(idx_ratio_aux_open_uv, lim(10'h000));
    rd(idx_abs_aux_open_uv, lim(10'h000));
    rd(idx_comp_accuracy_ov, lim(lim_ones));
    rd(idx_status, 32'h0);
    // unmapped place answers with an error
    wr(8'h45, 32'hFFFF, resp_slverr);
    rd(8'h45, 32'h0, resp_slverr);
    wr(idx_mask, 32'h7);
    msk = 3'h7;
    // cell open limit, low bits written as ones
    wr(idx_cell_open_uv, {16'h0, 10'h100, 6'h3F});
    rd(idx_cell_open_uv, lim(10'h100));
    smp(kind_cell, 10'h0FF, 1'b0);
    al(3'h0);
    wr(idx_ctrl, 32'h60);
    smp(kind_cell, 10'h100, 1'b0);
    al(3'h0);
    smp(kind_cell, 10'h0FF, 1'b0);
    al(3'h1);
    rd(idx_status, 32'h0);
    wr(idx_cell_open_uv, lim(10'h000));
    smp(kind_cell, 10'h000, 1'b0);
    al(3'h0);
    // auxiliary limits picked by reference select
    wr(idx_ratio_aux_open_uv, lim(10'h080));
    smp(kind_aux, 10'h07F, 1'b0);
    al(3'h2);
    smp(kind_aux, 10'h07F, 1'b1);
    al(3'h0);
    wr(idx_abs_aux_open_uv, {16'h0, 10'h200, 6'h15});
    rd(idx_abs_aux_open_uv, lim(10'h200));
    smp(kind_aux, 10'h1FF, 1'b1);
    al(3'h2);
    smp(kind_aux, 10'h200, 1'b1);
    al(3'h0);
    wr(idx_ratio_aux_open_uv, lim(10'h000));
    smp(kind_aux, 10'h07F, 1'b0);
    al(3'h0);
    // accuracy overvoltage limit
    smp(kind_acc, 10'h3FF, 1'b0);
    al(3'h0);
    wr(idx_comp_accuracy_ov, {16'h0, 10'h1D8, 6'h2A});
    rd(idx_comp_accuracy_ov, lim(10'h1D8));
    smp(kind_acc, 10'h1D8, 1'b0);
    al(3'h0);
    smp(kind_acc, 10'h1D9, 1'b0);
    al(3'h4);
    // unused sample kind raises nothing
    smp(2'h3, 10'h3FF, 1'b0);
    al(3'h0);
    // end-of-sequence start for every scan code, enable off and on
    for (int e = 0; e < 2; e++) begin
      for (int s = 0; s < 8; s++) begin
        wr(idx_ctrl, 32'h60 | (e << 4) | s);
        @(posedge aclk);
        seq_done <= 1'b1;
        @(negedge aclk);
        chk(acc_check_start, (e == 1) && (s == 1 || s == 2));
        @(posedge aclk);
        seq_done <= 1'b0;
      end
    end
    // masked alert keeps irq low while status holds
    wr(idx_mask, 32'h0);
    msk = 3'h0;
    smp(kind_acc, 10'h3FF, 1'b0);
    rd(idx_status, 32'h4);
    al(3'h4);
    // upper byte lane alone, then an alert left set going into reset
    wr(idx_cell_open_uv, 32'hFFFF, resp_okay, 4'h2);
    rd(idx_cell_open_uv, lim(10'h3FC));
    smp(kind_acc, 10'h3FF, 1'b0);
    // reset in mid-run brings the limit back to all ones
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(idx_comp_accuracy_ov, lim(lim_ones));
    rd(idx_cell_open_uv, lim(10'h000));
    rd(idx_ctrl, 32'h0);
    al(3'h0);
    // aux open check stays off while its select is clear
    wr(idx_ratio_aux_open_uv, lim(10'h080));
    smp(kind_aux, 10'h07F, 1'b0);
    al(3'h0);
    complete_run();
  end
endmodule // comparator_diag_thresholds_tb
`default_nettype wire

// File: limit_compare.sv
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// strict unsigned compare of a result against one limit
module limit_compare (
  input wire logic [comp_diag_pkg::lim_w-1:0] result,
  input wire logic [comp_diag_pkg::lim_w-1:0] limit,
  input wire logic check_over,
  output logic hit
);
  import comp_diag_pkg::*;
  // under: result < limit (zero never hits); over: result > limit
  always_comb begin
    if (check_over) begin
      hit = (result > limit);
    end else begin
      hit = (result < limit);
    end
  end
endmodule // limit_compare
`default_nettype wire
